// [hw/style_cfg_pkg.sv]
// Constants, offsets and bus carriers for the structure layout configuration block
package style_cfg_pkg;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] OFS_CTRL_STYLE_ALIAS = 8'h00;
	localparam logic [7:0] OFS_BUS_CFG_STYLE    = 8'h04;
	localparam logic [7:0] OFS_RUN_CTRL         = 8'h08;
	localparam logic [7:0] OFS_BUS_SIZE_CTRL    = 8'h0C;
	localparam logic [7:0] OFS_INIT_ADDR_UPPER  = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS       = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK         = 8'h18;

	// ********************************
	// Field positions
	// ********************************
	localparam int STYLE_LSB        = 0;
	localparam int STYLE_W          = 8;
	localparam int WIDTH_FLAG_BIT   = 8;
	localparam int ADV_PARITY_BIT   = 10;
	localparam int STOP_BIT         = 0;
	localparam int SUSPEND_BIT      = 1;
	localparam int SOFT_RESET_BIT   = 2;
	localparam int IO_DWORD_BIT     = 7;
	localparam int INIT_BLOCK_ADDRESS_HI_LSB      = 8;
	localparam int EV_BUF_PARITY    = 0;
	localparam int EV_WRITE_REFUSED = 1;
	localparam int EV_STYLE_RSVD    = 2;
	localparam int EV_W             = 3;

	// ********************************
	// Layout select encodings
	// ********************************
	localparam logic [7:0] STYLE_LEGACY16   = 8'h00;
	localparam logic [7:0] STYLE_RESERVED1  = 8'h01;
	localparam logic [7:0] STYLE_WIDE_NOBST = 8'h02;
	localparam logic [7:0] STYLE_WIDE_BURST = 8'h03;

	// ********************************
	// Values after hard reset
	// ********************************
	localparam logic [7:0]  STYLE_RST     = 8'h00;
	localparam logic        ADV_PAR_RST   = 1'b0;
	localparam logic        STOP_RST      = 1'b1;
	localparam logic        SUSPEND_RST   = 1'b0;
	localparam logic        IO_DWORD_RST  = 1'b0;
	localparam logic [15:0] INIT_UPPER_RST = 16'h0000;
	localparam logic [EV_W-1:0] IRQ_RST   = 3'h0;

	// ********************************
	// Bus answers
	// ********************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Master to slave signals of the AXI4-Lite register bus
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_m2s_type;

	// Slave to master signals of the AXI4-Lite register bus
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_s2m_type;

endpackage

// [hw/layout_config.sv]
// Structure layout configuration register bank with AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module layout_config
(
	input  wire logic                       clock,
	input  wire logic                       nrst,
	input  wire style_cfg_pkg::axil_m2s_type bus_req,
	output      style_cfg_pkg::axil_s2m_type bus_rsp,
	input  wire logic [31:0]                ptr_addr,
	input  wire logic                       master_data_parity_err,
	input  wire logic                       target_data_parity_err,
	input  wire logic                       addr_parity_err,
	input  wire logic                       desc_is_rx,
	output      logic [31:0]                master_addr,
	output      logic                       rx_descriptor_word_one_bpe_set,
	output      logic                       tx_descriptor_word_one_bpe_set,
	output      logic                       parity_err_report,
	output      logic                       structure_width_flag,
	output      logic [7:0]                 structure_layout_select,
	output      logic                       burst_desc_allowed,
	output      logic                       adv_parity_err_enable,
	output      logic                       io_doubleword_select,
	output      logic                       stop,
	output      logic                       suspend_request_bit,
	output      logic                       soft_reset_pulse,
	output      logic                       irq
);
	import style_cfg_pkg::*;

	// ********************************
	// Storage
	// ********************************
	axil_s2m_type    rsp_r;
	logic            aw_held_r;
	logic [7:0]      aw_addr_r;
	logic            w_held_r;
	logic [31:0]     w_data_r;
	logic [3:0]      w_strb_r;
	logic [7:0]      style_r;
	logic            flag_r;
	logic            adv_par_r;
	logic            stop_r;
	logic            susp_r;
	logic            soft_rst_r;
	logic            io_dw_r;
	logic [15:0]     init_upper_r;
	logic [EV_W-1:0] irq_stat_r;
	logic [EV_W-1:0] irq_mask_r;
	logic            irq_r;
	logic [31:0]     maddr_r;
	logic            rx_bpe_r;
	logic            tx_bpe_r;
	logic            par_rep_r;
	logic            burst_r;

	// ********************************
	// Write channel handshake
	// ********************************
	logic        take_aw;
	logic        take_w;
	logic        do_write;
	logic        aw_held_nxt;
	logic        w_held_nxt;
	logic        bvalid_nxt;
	logic [31:0] wmask;

	// Address and data are taken in either order, the write lands once both are held
	assign take_aw     = bus_req.awvalid & rsp_r.awready;
	assign take_w      = bus_req.wvalid & rsp_r.wready;
	assign do_write    = aw_held_r & w_held_r & ~rsp_r.bvalid;
	assign aw_held_nxt = (aw_held_r | take_aw) & ~do_write;
	assign w_held_nxt  = (w_held_r | take_w) & ~do_write;
	assign bvalid_nxt  = do_write | (rsp_r.bvalid & ~bus_req.bready);
	assign wmask       = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

	// Write address decode
	logic wr_style;
	logic wr_run;
	logic wr_bsize;
	logic wr_init_block_address;
	logic wr_stat;
	logic wr_mask;
	logic wr_hit;
	assign wr_style = do_write & ((aw_addr_r == OFS_CTRL_STYLE_ALIAS) |
		(aw_addr_r == OFS_BUS_CFG_STYLE));
	assign wr_run   = do_write & (aw_addr_r == OFS_RUN_CTRL);
	assign wr_bsize = do_write & (aw_addr_r == OFS_BUS_SIZE_CTRL);
	assign wr_init_block_address  = do_write & (aw_addr_r == OFS_INIT_ADDR_UPPER);
	assign wr_stat  = do_write & (aw_addr_r == OFS_IRQ_STATUS);
	assign wr_mask  = do_write & (aw_addr_r == OFS_IRQ_MASK);
	assign wr_hit   = wr_style | wr_run | wr_bsize | wr_init_block_address | wr_stat | wr_mask;

	// ********************************
	// Style register update
	// ********************************
	logic        halted;
	logic [31:0] style_word;
	logic [31:0] style_merge;
	logic        style_ok;
	logic [7:0]  style_nxt;
	logic        adv_par_nxt;
	logic        flag_nxt;
	logic        style_rsvd;

	// Style and parity enable only move while stopped or suspended
	assign halted      = stop_r | susp_r;
	assign style_word  = {21'h000000, adv_par_r, 1'b0, flag_r, style_r};
	assign style_merge = (style_word & ~wmask) | (w_data_r & wmask);
	assign style_ok    = wr_style & halted;
	assign style_nxt   = style_ok ? style_merge[STYLE_LSB +: STYLE_W] : style_r;
	assign adv_par_nxt = style_ok ? style_merge[ADV_PARITY_BIT] : adv_par_r;
	// Any nonzero layout is a wide one; reserved codes fall on the wide side
	assign flag_nxt    = (style_nxt != STYLE_LEGACY16);
	assign style_rsvd  = style_ok & (style_nxt != STYLE_LEGACY16) &
		(style_nxt != STYLE_WIDE_NOBST) & (style_nxt != STYLE_WIDE_BURST);

	// Hard reset, or a style write of the legacy code while halted, returns the layout to legacy
	always_ff @(posedge clock) begin
		if (!nrst) begin
			style_r   <= STYLE_RST;
			adv_par_r <= ADV_PAR_RST;
			flag_r    <= 1'b0;
			burst_r   <= 1'b0;
		end else begin
			style_r   <= style_nxt;
			adv_par_r <= adv_par_nxt;
			flag_r    <= flag_nxt;
			burst_r   <= (style_nxt == STYLE_WIDE_BURST);
		end
	end

	// ********************************
	// Run control, bus size and init address
	// ********************************
	logic [31:0] run_merge;
	logic [31:0] bsize_merge;
	logic [31:0] init_block_address_merge;
	assign run_merge   = ({29'h0, 1'b0, susp_r, stop_r} & ~wmask) | (w_data_r & wmask);
	assign bsize_merge = ({24'h0, io_dw_r, 7'h00} & ~wmask) | (w_data_r & wmask);
	assign init_block_address_merge  = ({16'h0000, init_upper_r} & ~wmask) | (w_data_r & wmask);

	// Soft reset is a one-cycle strobe and never touches the style storage
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stop_r       <= STOP_RST;
			susp_r       <= SUSPEND_RST;
			soft_rst_r   <= 1'b0;
			io_dw_r      <= IO_DWORD_RST;
			init_upper_r <= INIT_UPPER_RST;
		end else begin
			stop_r       <= wr_run ? run_merge[STOP_BIT] : stop_r;
			susp_r       <= wr_run ? run_merge[SUSPEND_BIT] : susp_r;
			soft_rst_r   <= wr_run & run_merge[SOFT_RESET_BIT];
			io_dw_r      <= wr_bsize ? bsize_merge[IO_DWORD_BIT] : io_dw_r;
			init_upper_r <= wr_init_block_address ? init_block_address_merge[15:0] : init_upper_r;
		end
	end

	// ********************************
	// Master address and parity path
	// ********************************
	logic [31:0] maddr_nxt;
	logic        bpe_hit;
	// Legacy structures carry 24 address bits, so the top byte comes from init address
	assign maddr_nxt = flag_r ? ptr_addr :
		{init_upper_r[INIT_BLOCK_ADDRESS_HI_LSB +: 8], ptr_addr[23:0]};
	// Marking needs the extra descriptor bit of the wide layouts
	assign bpe_hit   = master_data_parity_err & adv_par_r & flag_r;

	// All 32 address bits are registered and driven in every layout
	always_ff @(posedge clock) begin
		if (!nrst) begin
			maddr_r   <= 32'h00000000;
			rx_bpe_r  <= 1'b0;
			tx_bpe_r  <= 1'b0;
			par_rep_r <= 1'b0;
		end else begin
			maddr_r   <= maddr_nxt;
			rx_bpe_r  <= bpe_hit & desc_is_rx;
			tx_bpe_r  <= bpe_hit & ~desc_is_rx;
			par_rep_r <= addr_parity_err | target_data_parity_err |
				master_data_parity_err;
		end
	end

	// ********************************
	// Interrupt status and mask
	// ********************************
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] stat_clr;
	logic [EV_W-1:0] stat_nxt;
	logic [EV_W-1:0] mask_nxt;
	assign ev_set   = {style_rsvd, wr_style & ~halted, bpe_hit};
	assign stat_clr = wr_stat ? (w_data_r[EV_W-1:0] & wmask[EV_W-1:0]) : {EV_W{1'b0}};
	// A new event in the clearing cycle stays set
	assign stat_nxt = (irq_stat_r & ~stat_clr) | ev_set;
	assign mask_nxt = wr_mask ? ((irq_mask_r & ~wmask[EV_W-1:0]) |
		(w_data_r[EV_W-1:0] & wmask[EV_W-1:0])) : irq_mask_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_stat_r <= IRQ_RST;
			irq_mask_r <= IRQ_RST;
			irq_r      <= 1'b0;
		end else begin
			irq_stat_r <= stat_nxt;
			irq_mask_r <= mask_nxt;
			irq_r      <= |(stat_nxt & mask_nxt);
		end
	end

	// ********************************
	// Read channel
	// ********************************
	logic        take_ar;
	logic        rvalid_nxt;
	logic        rd_hit;
	logic [31:0] rd_data;
	logic [31:0] style_read;
	assign take_ar    = bus_req.arvalid & rsp_r.arready;
	assign rvalid_nxt = take_ar | (rsp_r.rvalid & ~bus_req.rready);
	// Layout select reads back only while halted; flag and enable always; reserved zero
	assign style_read = {21'h000000, adv_par_r, 1'b0, flag_r,
		halted ? style_r : 8'h00};
	assign rd_hit = (bus_req.araddr == OFS_CTRL_STYLE_ALIAS) |
		(bus_req.araddr == OFS_BUS_CFG_STYLE) | (bus_req.araddr == OFS_RUN_CTRL) |
		(bus_req.araddr == OFS_BUS_SIZE_CTRL) | (bus_req.araddr == OFS_INIT_ADDR_UPPER) |
		(bus_req.araddr == OFS_IRQ_STATUS) | (bus_req.araddr == OFS_IRQ_MASK);

	// Read data selection, both style offsets see the same word
	always_comb begin
		rd_data = 32'h00000000;
		unique case (bus_req.araddr)
			OFS_CTRL_STYLE_ALIAS: rd_data = style_read;
			OFS_BUS_CFG_STYLE:    rd_data = style_read;
			OFS_RUN_CTRL:         rd_data = {30'h00000000, susp_r, stop_r};
			OFS_BUS_SIZE_CTRL:    rd_data = {24'h000000, io_dw_r, 7'h00};
			OFS_INIT_ADDR_UPPER:  rd_data = {16'h0000, init_upper_r};
			OFS_IRQ_STATUS:       rd_data = {29'h00000000, irq_stat_r};
			OFS_IRQ_MASK:         rd_data = {29'h00000000, irq_mask_r};
			default:              rd_data = 32'h00000000;
		endcase
	end

	// ********************************
	// Bus handshake registers
	// ********************************
	// One write and one read in flight; ready stays low until the answer is taken
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rsp_r     <= '0;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			aw_held_r     <= aw_held_nxt;
			w_held_r      <= w_held_nxt;
			aw_addr_r     <= take_aw ? bus_req.awaddr : aw_addr_r;
			w_data_r      <= take_w ? bus_req.wdata : w_data_r;
			w_strb_r      <= take_w ? bus_req.wstrb : w_strb_r;
			rsp_r.awready <= ~aw_held_nxt & ~bvalid_nxt;
			rsp_r.wready  <= ~w_held_nxt & ~bvalid_nxt;
			rsp_r.bvalid  <= bvalid_nxt;
			rsp_r.bresp   <= do_write ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : rsp_r.bresp;
			rsp_r.arready <= ~rvalid_nxt;
			rsp_r.rvalid  <= rvalid_nxt;
			rsp_r.rdata   <= take_ar ? rd_data : rsp_r.rdata;
			rsp_r.rresp   <= take_ar ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rsp_r.rresp;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign bus_rsp                        = rsp_r;
	assign master_addr                    = maddr_r;
	assign rx_descriptor_word_one_bpe_set = rx_bpe_r;
	assign tx_descriptor_word_one_bpe_set = tx_bpe_r;
	assign parity_err_report              = par_rep_r;
	assign structure_width_flag           = flag_r;
	assign structure_layout_select        = style_r;
	assign burst_desc_allowed             = burst_r;
	assign adv_parity_err_enable          = adv_par_r;
	assign io_doubleword_select           = io_dw_r;
	assign stop                           = stop_r;
	assign suspend_request_bit            = susp_r;
	assign soft_reset_pulse               = soft_rst_r;
	assign irq                            = irq_r;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// A style write lands either refused or taken, depending on the halt state
	sequence s_run_write;
		wr_style && !halted;
	endsequence
	sequence s_halt_write;
		wr_style && halted;
	endsequence
	// A landed run control write that asks for a soft reset
	sequence s_soft_request;
		wr_run && run_merge[SOFT_RESET_BIT];
	endsequence
	// A read of either style offset accepted on the bus
	sequence s_style_read;
		take_ar && ((bus_req.araddr == OFS_CTRL_STYLE_ALIAS) ||
			(bus_req.araddr == OFS_BUS_CFG_STYLE));
	endsequence

	// Style storage: refused while running, taken while halted, kept by soft reset
	a_style_run_hold: assert property (s_run_write |=>
		$stable(style_r) && $stable(adv_par_r))
		else $error("style storage changed by write while running");
	a_refused_flagged: assert property (s_run_write |=> irq_stat_r[EV_WRITE_REFUSED])
		else $error("refused style write not flagged");
	a_style_halt_take: assert property (s_halt_write |=> style_r == $past(style_merge[7:0]))
		else $error("style write while halted not stored");
	a_reset_legacy: assert property ($rose(nrst) |->
		style_r == STYLE_RST && !flag_r && !adv_par_r)
		else $error("style storage not cleared by hard reset");
	a_soft_keeps_style: assert property (s_soft_request |=>
		soft_rst_r && $stable(style_r) && $stable(flag_r) && $stable(adv_par_r))
		else $error("soft reset disturbed style storage");
	a_flag_from_style: assert property (flag_r == (style_r != 8'h00))
		else $error("width flag disagrees with style");
	a_burst_from_style: assert property (burst_desc_allowed == (style_r == STYLE_WIDE_BURST))
		else $error("burst permission disagrees with style");
	a_rsvd_flagged: assert property (style_rsvd |=> irq_stat_r[EV_STYLE_RSVD])
		else $error("reserved style code not flagged");

	// Address and parity paths
	a_addr_legacy_top: assert property (!flag_r |=>
		master_addr[31:24] == $past(init_upper_r[15:8]))
		else $error("legacy upper address byte not from init address");
	a_addr_wide_full: assert property (flag_r |=> master_addr == $past(ptr_addr))
		else $error("wide layout address not taken whole");
	a_bpe_cause: assert property ((rx_bpe_r || tx_bpe_r) |->
		$past(master_data_parity_err && adv_par_r))
		else $error("parity flag set without enabled data parity error");
	a_bpe_wide_only: assert property ((rx_bpe_r || tx_bpe_r) |-> $past(flag_r))
		else $error("parity flag set in a legacy layout");
	a_bpe_status: assert property (bpe_hit |=> irq_stat_r[EV_BUF_PARITY])
		else $error("buffer parity event not flagged");
	a_report_indep: assert property ((addr_parity_err || target_data_parity_err) |=>
		parity_err_report)
		else $error("parity report suppressed");

	// Bus answers
	a_write_answer: assert property (do_write |=> bus_rsp.bvalid ##0 !bus_rsp.awready)
		else $error("write not answered next cycle");
	a_style_rsvd_zero: assert property (take_ar && (bus_req.araddr == OFS_BUS_CFG_STYLE)
		|=> bus_rsp.rdata[31:11] == 21'h000000 && !bus_rsp.rdata[9])
		else $error("reserved style bits not zero");
	a_read_alias: assert property (s_style_read |=> bus_rsp.rdata == $past(style_read))
		else $error("style offsets read different words");

endmodule

// [tb/tb_software_style_config.sv]
// Self-checking bench for the structure layout configuration register bank
`timescale 1ns/1ps
module tb_software_style_config;
	import style_cfg_pkg::*;

	// ********************************
	// Signals
	// ********************************
	logic         clock                  = 1'b0;
	logic         nrst                   = 1'b0;
	axil_m2s_type bus_req                = '0;
	axil_s2m_type bus_rsp;
	logic [31:0]  ptr_addr               = 32'h0000_0000;
	logic         master_data_parity_err = 1'b0;
	logic         target_data_parity_err = 1'b0;
	logic         addr_parity_err        = 1'b0;
	logic         desc_is_rx             = 1'b0;
	logic [31:0]  master_addr;
	logic         rx_bpe;
	logic         tx_bpe;
	logic         parity_err_report;
	logic         structure_width_flag;
	logic [7:0]   structure_layout_select;
	logic         burst_desc_allowed;
	logic         adv_parity_err_enable;
	logic         io_doubleword_select;
	logic         stop;
	logic         suspend_request_bit;
	logic         irq;
	logic         soft_pulse;
	logic [31:0]  lfsr_r                 = 32'h0000_0043;
	logic [15:0]  init_hi;
	logic [33:0]  exp_b[$];
	logic [33:0]  exp_r[$];
	int           mismatches             = 0;
	int           comparisons            = 0;
	int           soft_pulses            = 0;
	int           i;
	logic [7:0]   styles[5]              = '{8'h01, 8'hFF, 8'h02, 8'h00, 8'h03};

	// Half period of 50 ns gives the 10 MHz clock
	always #50 clock = ~clock;

	layout_config u_dut (
		.clock                          (clock),
		.nrst                           (nrst),
		.bus_req                        (bus_req),
		.bus_rsp                        (bus_rsp),
		.ptr_addr                       (ptr_addr),
		.master_data_parity_err         (master_data_parity_err),
		.target_data_parity_err         (target_data_parity_err),
		.addr_parity_err                (addr_parity_err),
		.desc_is_rx                     (desc_is_rx),
		.master_addr                    (master_addr),
		.rx_descriptor_word_one_bpe_set (rx_bpe),
		.tx_descriptor_word_one_bpe_set (tx_bpe),
		.parity_err_report              (parity_err_report),
		.structure_width_flag           (structure_width_flag),
		.structure_layout_select        (structure_layout_select),
		.burst_desc_allowed             (burst_desc_allowed),
		.adv_parity_err_enable          (adv_parity_err_enable),
		.io_doubleword_select           (io_doubleword_select),
		.stop                           (stop),
		.suspend_request_bit            (suspend_request_bit),
		.soft_reset_pulse               (soft_pulse),
		.irq                            (irq)
	);

	// ********************************
	// Compare and report
	// ********************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check_bus(input string what, input logic [33:0] exp, input logic [33:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic time_out;
		mismatches++;
		$display("wrong value handshake wait expected done seen stuck");
		complete_run();
	endtask

	// Monitor pops the oldest note whenever an answer is handed over
	always @(posedge clock) begin
		if (nrst && bus_rsp.bvalid && bus_req.bready) begin
			check_bus("write response", exp_b.pop_front(), {32'h0, bus_rsp.bresp});
		end
		if (nrst && bus_rsp.rvalid && bus_req.rready) begin
			check_bus("read answer", exp_r.pop_front(), {bus_rsp.rresp, bus_rsp.rdata});
		end
		// Strobe cycles are counted, so a stretched pulse shows as a count above one
		if (nrst && soft_pulse) begin
			soft_pulses++;
		end
	end

	// ********************************
	// Bus master tasks
	// ********************************
	// Each starts one edge later so no signal is assigned twice in one step
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clock);
		exp_b.push_back({32'h0, r});
		bus_req.awaddr <= a;
		bus_req.awvalid <= 1'b1;
		bus_req.wdata <= d;
		bus_req.wstrb <= 4'hF;
		bus_req.wvalid <= 1'b1;
		bus_req.bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (bus_req.awvalid && bus_rsp.awready) bus_req.awvalid <= 1'b0;
			if (bus_req.wvalid && bus_rsp.wready) bus_req.wvalid <= 1'b0;
			if (bus_rsp.bvalid) break;
		end
		bus_req.bready <= 1'b0;
		if (n == 40) time_out();
	endtask

	task automatic bus_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clock);
		exp_r.push_back({r, d});
		bus_req.araddr <= a;
		bus_req.arvalid <= 1'b1;
		bus_req.rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (bus_req.arvalid && bus_rsp.arready) bus_req.arvalid <= 1'b0;
			if (bus_rsp.rvalid) break;
		end
		bus_req.rready <= 1'b0;
		if (n == 40) time_out();
	endtask

	// ********************************
	// Datapath stimulus tasks
	// ********************************
	// Fault pulse of one cycle; outputs are looked at one cycle later
	task automatic pulse_parity(input int k, input logic en);
		@(posedge clock);
		master_data_parity_err <= (k < 2);
		desc_is_rx <= (k == 0);
		target_data_parity_err <= (k == 2);
		addr_parity_err <= (k == 3);
		@(posedge clock);
		master_data_parity_err <= 1'b0;
		target_data_parity_err <= 1'b0;
		addr_parity_err <= 1'b0;
		@(negedge clock);
		check_pin("rx parity mark", {31'h0, en && k == 0}, {31'h0, rx_bpe});
		check_pin("tx parity mark", {31'h0, en && k == 1}, {31'h0, tx_bpe});
		check_pin("parity report", 32'h1, {31'h0, parity_err_report});
		@(negedge clock);
		check_pin("rx mark end", 32'h0, {31'h0, rx_bpe | tx_bpe});
	endtask

	task automatic check_addr(input logic wide);
		@(posedge clock);
		lfsr_r = lfsr_next(lfsr_r);
		ptr_addr <= lfsr_r;
		@(posedge clock);
		@(negedge clock);
		check_pin("master address",
			wide ? lfsr_r : {init_hi[15:8], lfsr_r[23:0]}, master_addr);
	endtask

	task automatic wait_irq(input logic v);
		for (int n = 0; n < 20 && irq !== v; n++) @(negedge clock);
		check_pin("interrupt", {31'h0, v}, {31'h0, irq});
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		bus_read(OFS_CTRL_STYLE_ALIAS, 32'h0, RESP_OKAY);
		bus_read(OFS_RUN_CTRL, 32'h1, RESP_OKAY);
		// Every encoding through alternating aliases, width flag written as one
		for (i = 0; i < 5; i++) begin
			bus_write(i[0] ? OFS_BUS_CFG_STYLE : OFS_CTRL_STYLE_ALIAS,
				{23'h0, 1'b1, styles[i]}, RESP_OKAY);
			bus_read(i[0] ? OFS_CTRL_STYLE_ALIAS : OFS_BUS_CFG_STYLE,
				{23'h0, styles[i] != 8'h00, styles[i]}, RESP_OKAY);
			@(negedge clock);
			check_pin("width flag", {31'h0, styles[i] != 8'h00}, {31'h0, structure_width_flag});
			check_pin("burst select", {31'h0, styles[i] == STYLE_WIDE_BURST},
				{31'h0, burst_desc_allowed});
		end
		bus_read(OFS_IRQ_STATUS, 32'h4, RESP_OKAY);
		bus_write(OFS_IRQ_STATUS, 32'h4, RESP_OKAY);
		bus_read(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
		// Parity marking needs the enable; the other reports never do
		for (i = 0; i < 4; i++) pulse_parity(i, 1'b0);
		bus_write(OFS_BUS_CFG_STYLE, 32'h0000_0403, RESP_OKAY);
		bus_read(OFS_CTRL_STYLE_ALIAS, 32'h0000_0503, RESP_OKAY);
		for (i = 0; i < 4; i++) pulse_parity(i, 1'b1);
		check_addr(1'b1);
		// Running: style writes are dropped, field reads gated, refusal raises irq
		bus_write(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
		bus_write(OFS_RUN_CTRL, 32'h0, RESP_OKAY);
		bus_write(OFS_CTRL_STYLE_ALIAS, 32'h0, RESP_OKAY);
		bus_read(OFS_BUS_CFG_STYLE, 32'h0000_0500, RESP_OKAY);
		@(negedge clock);
		check_pin("stored select", 32'h3, {24'h0, structure_layout_select});
		check_pin("parity enable", 32'h1, {31'h0, adv_parity_err_enable});
		wait_irq(1'b1);
		bus_write(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
		wait_irq(1'b0);
		// Suspend alone also opens the field
		bus_write(OFS_RUN_CTRL, 32'h2, RESP_OKAY);
		@(negedge clock);
		check_pin("run state", 32'h2, {30'h0, suspend_request_bit, stop});
		bus_write(OFS_CTRL_STYLE_ALIAS, 32'h2, RESP_OKAY);
		bus_write(OFS_RUN_CTRL, 32'h5, RESP_OKAY);
		@(negedge clock);
		check_pin("run state", 32'h1, {30'h0, suspend_request_bit, stop});
		bus_read(OFS_BUS_CFG_STYLE, 32'h0000_0102, RESP_OKAY);
		bus_write(OFS_BUS_CFG_STYLE, 32'h0, RESP_OKAY);
		lfsr_r = lfsr_next(lfsr_r);
		init_hi = lfsr_r[15:0];
		bus_write(OFS_INIT_ADDR_UPPER, {16'h0, init_hi}, RESP_OKAY);
		bus_read(OFS_INIT_ADDR_UPPER, {16'h0, init_hi}, RESP_OKAY);
		for (i = 0; i < 3; i++) check_addr(1'b0);
		// Access width follows only its own bit
		bus_write(OFS_BUS_SIZE_CTRL, 32'h80, RESP_OKAY);
		@(negedge clock);
		check_pin("io width", 32'h1, {31'h0, io_doubleword_select});
		check_pin("flag kept", 32'h0, {31'h0, structure_width_flag});
		bus_write(8'h1C, 32'h3, RESP_SLVERR);
		bus_read(OFS_CTRL_STYLE_ALIAS, 32'h0, RESP_OKAY);
		repeat (4) @(posedge clock);
		check_pin("soft strobes", 32'h1, soft_pulses);
		complete_run();
	end
endmodule
